// ---- rtl/ddr4ci_ca_decode.sv ----
// Contract
// - Row address taken on activate, column address on read or write
// - Mode register set loads op-code from address pins
// - A17 used only by x4 organisation
// - A10 high on read/write requests auto precharge
// - A10 on precharge: low one bank, high all banks
// - Single-bank precharge target from bank group and bank pins
// - A12 high full burst, low on-the-fly burst chop
// - Activate decoded when activate pin low with chip select
// - During activate, row/column/write pins are row bits 16,15,14
// - Bank pins pick bank for activate/read/write/precharge and mode reg
// - Bank group pins pick group; x16 uses only group bit 0
// - Stacked dies decode chip ID as part of command
// - All command/address inputs sampled on rising clock edge
// - Clock enable low enters precharge/active power-down or self refresh
// - Clock enable rise exits self refresh without command clocking
// - Power-down disables inputs except clock, ODT, reset, clock enable
// - Self refresh disables inputs except clock enable and reset
// - Commands ignored while chip select high
// - Chip select is part of command code, selects rank
// - Activate pin high: row/column/write pins encode command
// - Reset low holds device in reset; normal only while high
`timescale 1ns/100ps
`include "ddr4ci_defs.svh"

module ddr4ci_ca_decode
  import ddr4ci_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire ddr4ci_ca_t ca,
  input wire logic cke,
  input wire logic [1:0] org,
  input wire logic [1:0] stack,
  input wire logic [2:0] die_id,
  output ddr4ci_cmd_t cmd,
  output ddr4ci_pwr_t pwr_state,
  output logic [15:0] bank_open,
  output logic ibuf_ca_en,
  output logic ibuf_ck_odt_en,
  output logic dev_ready
);

  ddr4ci_cmd_t cmd_ff;
  ddr4ci_cmd_t nxt_cmd;
  ddr4ci_pwr_t pwr_ff;
  ddr4ci_pwr_t nxt_pwr;
  logic cke_ff;
  logic ibuf_ca_en_ff;
  logic nxt_ibuf_ca_en;
  logic ibuf_ck_odt_en_ff;
  logic nxt_ibuf_ck_odt_en;
  logic ready_ff;
  logic [15:0] open_w;

  // Organisation straps
  wire is_x4 = (org == `DDR4CI_ORG_X4);
  wire is_x16 = (org == `DDR4CI_ORG_X16);

  // Chip ID bits in use; x16 never stacks this way
  logic [2:0] cid_mask;
  always_comb begin
    case (stack)
      `DDR4CI_STACK_2H: cid_mask = `DDR4CI_CID_MASK_2H;
      `DDR4CI_STACK_4H: cid_mask = `DDR4CI_CID_MASK_4H;
      `DDR4CI_STACK_8H: cid_mask = `DDR4CI_CID_MASK_8H;
      default: cid_mask = `DDR4CI_CID_MASK_1H;
    endcase
    if (is_x16) begin
      cid_mask = `DDR4CI_CID_MASK_1H;
    end
  end

  // Chip select and chip ID form part of the command code
  wire sel = ~ca.cs_n;
  wire die_hit = (((ca.cid ^ die_id) & cid_mask) == 3'h0);

  // Command/address buffers live only in normal operation with the
  // previous clock enable high; pins are sampled at the rising edge
  wire ca_live = (pwr_ff == DDR4CI_PS_ACTIVE) & cke_ff;
  wire take = sel & die_hit & ca_live;

  wire [2:0] rcw = {ca.ras_n_a16, ca.cas_n_a15, ca.we_n_a14};
  wire non_act = take & ca.act_n;
  wire is_act = take & ~ca.act_n;
  wire is_mrs = non_act & (rcw == `DDR4CI_RCW_MRS);
  wire is_refc = non_act & (rcw == `DDR4CI_RCW_REF);
  wire is_ref = is_refc & cke;
  wire is_sre = is_refc & ~cke;
  wire is_pre = non_act & (rcw == `DDR4CI_RCW_PRE);
  wire is_rfu = non_act & (rcw == `DDR4CI_RCW_RFU);
  wire is_wr = non_act & (rcw == `DDR4CI_RCW_WR);
  wire is_rd = non_act & (rcw == `DDR4CI_RCW_RD);
  wire is_zqc = non_act & (rcw == `DDR4CI_RCW_ZQC);
  wire is_rw = is_rd | is_wr;

  // Qualifiers
  wire ap_bit = ca.a[`DDR4CI_AP_BIT];
  wire auto_pre = is_rw & ap_bit;
  wire pre_all = is_pre & ap_bit;
  wire chop = is_rw & ~ca.a[`DDR4CI_BC_BIT];

  // Group bit 1 does not exist on x16
  wire [1:0] bg_eff = {ca.bg[1] & ~is_x16, ca.bg[0]};
  wire [3:0] bank_idx = {bg_eff, ca.ba};

  // Row: A17 only on x4; command pins double as A16..A14
  wire a17_eff = ca.a17 & is_x4;
  wire [17:0] row_addr = {a17_eff, ca.ras_n_a16, ca.cas_n_a15,
                          ca.we_n_a14, ca.a};
  wire [9:0] col_addr = ca.a[`DDR4CI_COL_MSB:0];

  wire any_open = |open_w;

  // Clock enable falling edge in normal operation
  wire cke_fall = ca_live & ~cke;
  wire cke_rise = ~cke_ff & cke;

  // Decoded command; nothing is decoded while buffers are off
  always_comb begin
    nxt_cmd = '0;
    nxt_cmd.bg = bg_eff;
    nxt_cmd.ba = ca.ba;
    nxt_cmd.die = ca.cid & cid_mask;
    if (is_act) begin
      nxt_cmd.valid = 1'b1;
      nxt_cmd.op = DDR4CI_OP_ACT;
      nxt_cmd.row = row_addr;
    end else if (is_rw) begin
      nxt_cmd.valid = 1'b1;
      nxt_cmd.op = is_rd ? DDR4CI_OP_RD : DDR4CI_OP_WR;
      nxt_cmd.col = col_addr;
      nxt_cmd.auto_pre = auto_pre;
      nxt_cmd.burst_chop = chop;
    end else if (is_pre) begin
      nxt_cmd.valid = 1'b1;
      nxt_cmd.op = DDR4CI_OP_PRE;
      nxt_cmd.pre_all = pre_all;
    end else if (is_mrs) begin
      nxt_cmd.valid = 1'b1;
      nxt_cmd.op = DDR4CI_OP_MRS;
      nxt_cmd.opcode = ca.a;
      nxt_cmd.mr_sel = {ca.bg[0], ca.ba};
    end else if (is_ref) begin
      nxt_cmd.valid = 1'b1;
      nxt_cmd.op = DDR4CI_OP_REF;
    end else if (is_sre && !any_open) begin
      nxt_cmd.valid = 1'b1;
      nxt_cmd.op = DDR4CI_OP_SRE;
    end else if (is_zqc) begin
      nxt_cmd.valid = 1'b1;
      nxt_cmd.op = DDR4CI_OP_ZQC;
    end else if (is_rfu) begin
      nxt_cmd.valid = 1'b1;
      nxt_cmd.op = DDR4CI_OP_RFU;
    end
  end

  // Power state; self refresh needs every bank idle, otherwise a
  // refresh with clock enable low falls back to power-down
  always_comb begin
    nxt_pwr = pwr_ff;
    case (pwr_ff)
      DDR4CI_PS_ACTIVE: begin
        if (cke_fall) begin
          if (is_sre && !any_open) begin
            nxt_pwr = DDR4CI_PS_SREF;
          end else if (any_open) begin
            nxt_pwr = DDR4CI_PS_APD;
          end else begin
            nxt_pwr = DDR4CI_PS_PPD;
          end
        end
      end
      DDR4CI_PS_PPD, DDR4CI_PS_APD: begin
        if (cke_rise) begin
          nxt_pwr = DDR4CI_PS_ACTIVE;
        end
      end
      DDR4CI_PS_SREF: begin
        // Clock enable watched directly, no command clocking needed
        if (cke) begin
          nxt_pwr = DDR4CI_PS_ACTIVE;
        end
      end
      default: begin
        nxt_pwr = DDR4CI_PS_ACTIVE;
      end
    endcase
  end

  // Input buffer enables follow the next power state
  always_comb begin
    nxt_ibuf_ca_en = 1'b0;
    nxt_ibuf_ck_odt_en = 1'b0;
    case (nxt_pwr)
      DDR4CI_PS_ACTIVE: begin
        nxt_ibuf_ca_en = 1'b1;
        nxt_ibuf_ck_odt_en = 1'b1;
      end
      DDR4CI_PS_PPD, DDR4CI_PS_APD: begin
        nxt_ibuf_ck_odt_en = 1'b1;
      end
      DDR4CI_PS_SREF: begin
        nxt_ibuf_ck_odt_en = 1'b0;
      end
      default: begin
        nxt_ibuf_ca_en = 1'b0;
      end
    endcase
  end

  // Bank open flags; activate opens, precharge or auto precharge closes.
  // Auto precharge closes at once: access timing is not modelled here.
  genvar gi;
  generate
    for (gi = 0; gi < `DDR4CI_NBANK; gi = gi + 1) begin : g_bank
      wire hit = (bank_idx == 4'(gi));
      wire set_w = is_act & hit;
      wire clr_w = (is_pre & (pre_all | hit)) | (auto_pre & hit);
      ddr4ci_bank #(
        .IDX(gi)
      ) u_bank (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .set_open(set_w),
        .clr_open(clr_w),
        .open_row(open_w[gi])
      );
    end
  endgenerate

  // Reset low holds everything idle with buffers off
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cmd_ff <= '0;
      pwr_ff <= DDR4CI_PS_ACTIVE;
      cke_ff <= `DDR4CI_RST_CKE;
      ibuf_ca_en_ff <= 1'b0;
      ibuf_ck_odt_en_ff <= 1'b0;
      ready_ff <= 1'b0;
    end else if (clk_en) begin
      cmd_ff <= nxt_cmd;
      pwr_ff <= nxt_pwr;
      cke_ff <= cke;
      ibuf_ca_en_ff <= nxt_ibuf_ca_en;
      ibuf_ck_odt_en_ff <= nxt_ibuf_ck_odt_en;
      ready_ff <= 1'b1;
    end
  end

  assign cmd = cmd_ff;
  assign pwr_state = pwr_ff;
  assign bank_open = open_w;
  assign ibuf_ca_en = ibuf_ca_en_ff;
  assign ibuf_ck_odt_en = ibuf_ck_odt_en_ff;
  assign dev_ready = ready_ff;

endmodule

// ---- common/ddr4ci_defs.svh ----
`ifndef DDR4CI_DEFS_SVH
`define DDR4CI_DEFS_SVH

// Device organisation straps
`define DDR4CI_ORG_X4 2'h0
`define DDR4CI_ORG_X8 2'h1
`define DDR4CI_ORG_X16 2'h2

// Stack height straps
`define DDR4CI_STACK_1H 2'h0
`define DDR4CI_STACK_2H 2'h1
`define DDR4CI_STACK_4H 2'h2
`define DDR4CI_STACK_8H 2'h3

// Chip ID masks per stack height
`define DDR4CI_CID_MASK_1H 3'h0
`define DDR4CI_CID_MASK_2H 3'h1
`define DDR4CI_CID_MASK_4H 3'h3
`define DDR4CI_CID_MASK_8H 3'h7

// Field positions on the address pins
`define DDR4CI_AP_BIT 10
`define DDR4CI_BC_BIT 12
`define DDR4CI_COL_MSB 9

// Command codes on {row, column, write-enable} pins with the
// activate pin high
`define DDR4CI_RCW_MRS 3'h0
`define DDR4CI_RCW_REF 3'h1
`define DDR4CI_RCW_PRE 3'h2
`define DDR4CI_RCW_RFU 3'h3
`define DDR4CI_RCW_WR 3'h4
`define DDR4CI_RCW_RD 3'h5
`define DDR4CI_RCW_ZQC 3'h6
`define DDR4CI_RCW_NOP 3'h7

// Sizes
`define DDR4CI_NBANK 16

// Reset values
`define DDR4CI_RST_BANKS 16'h0000
`define DDR4CI_RST_CKE 1'h0

`endif

// ---- common/ddr4ci_pkg.sv ----
package ddr4ci_pkg;

  typedef enum logic [3:0] {
    DDR4CI_OP_NONE = 4'h0,
    DDR4CI_OP_ACT = 4'h1,
    DDR4CI_OP_RD = 4'h2,
    DDR4CI_OP_WR = 4'h3,
    DDR4CI_OP_PRE = 4'h4,
    DDR4CI_OP_REF = 4'h5,
    DDR4CI_OP_MRS = 4'h6,
    DDR4CI_OP_ZQC = 4'h7,
    DDR4CI_OP_SRE = 4'h8,
    DDR4CI_OP_RFU = 4'h9
  } ddr4ci_op_t;

  typedef enum logic [3:0] {
    DDR4CI_PS_ACTIVE = 4'h1,
    DDR4CI_PS_PPD = 4'h2,
    DDR4CI_PS_APD = 4'h4,
    DDR4CI_PS_SREF = 4'h8
  } ddr4ci_pwr_t;

  // Command/address pins as sampled at the clock crossing
  typedef struct packed {
    logic cs_n;
    logic act_n;
    logic ras_n_a16;
    logic cas_n_a15;
    logic we_n_a14;
    logic a17;
    logic [13:0] a;
    logic [1:0] bg;
    logic [1:0] ba;
    logic [2:0] cid;
  } ddr4ci_ca_t;

  // Decoded command
  typedef struct packed {
    logic valid;
    ddr4ci_op_t op;
    logic [1:0] bg;
    logic [1:0] ba;
    logic [17:0] row;
    logic [9:0] col;
    logic auto_pre;
    logic burst_chop;
    logic pre_all;
    logic [13:0] opcode;
    logic [2:0] mr_sel;
    logic [2:0] die;
  } ddr4ci_cmd_t;

endpackage

// ---- rtl/ddr4ci_bank.sv ----
`timescale 1ns/100ps
`include "ddr4ci_defs.svh"

// One bank's open-row flag
module ddr4ci_bank #(
  parameter int IDX = 0
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic set_open,
  input wire logic clr_open,
  output logic open_row
);

  logic open_ff;
  logic nxt_open;

  // Activate beats a precharge in the same cycle
  assign nxt_open = set_open ? 1'b1 : (clr_open ? 1'b0 : open_ff);
  assign open_row = open_ff;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      open_ff <= 1'(`DDR4CI_RST_BANKS >> IDX);
    end else if (clk_en) begin
      open_ff <= nxt_open;
    end
  end

endmodule

// ---- test/ddr4ci_ca_decode_chk.sv ----
`timescale 1ns/100ps
module ddr4ci_ca_decode_chk
  import ddr4ci_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire ddr4ci_ca_t ca,
  input wire logic cke,
  input wire logic [2:0] die_id,
  input wire ddr4ci_cmd_t cmd,
  input wire ddr4ci_pwr_t pwr_state,
  input wire logic [15:0] bank_open,
  input wire logic ibuf_ca_en,
  input wire logic ibuf_ck_odt_en,
  input wire logic dev_ready
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire [2:0] rcw = {ca.ras_n_a16, ca.cas_n_a15, ca.we_n_a14};
  // Chip ID compared in full, so stacked masking never fires falsely
  sequence s_take;
    clk_en && dev_ready && $past(cke) && !ca.cs_n && ca.cid == die_id
      && pwr_state == DDR4CI_PS_ACTIVE;
  endsequence
  sequence s_cmd(c);
    s_take ##0 (ca.act_n && rcw == c);
  endsequence
  AST_ACT_ROW: assert property (s_take ##0 !ca.act_n |=>
    cmd.valid && cmd.row[16:0] == {$past(rcw), $past(ca.a)})
    else $error("activate row wrong");
  AST_CS_MASK: assert property (clk_en && ca.cs_n |=> !cmd.valid)
    else $error("deselected command decoded");
  AST_RD_WR: assert property (s_take ##0 ca.act_n && rcw[2:1] == 2'h2 |=>
    cmd.auto_pre == $past(ca.a[10]) && cmd.burst_chop == !$past(ca.a[12]))
    else $error("access qualifiers wrong");
  AST_PRE_ALL: assert property (s_cmd(3'h2) ##0 ca.a[10] |=>
    cmd.pre_all && bank_open == 16'h0000)
    else $error("precharge all wrong");
  AST_MRS: assert property (s_cmd(3'h0) |=> cmd.opcode == $past(ca.a))
    else $error("mode op-code wrong");
  AST_PD_ENTRY: assert property (clk_en && dev_ready && $past(cke) && !cke
    && ca.cs_n && pwr_state == DDR4CI_PS_ACTIVE |=> pwr_state ==
    ($past(bank_open) != 0 ? DDR4CI_PS_APD : DDR4CI_PS_PPD))
    else $error("power-down entry wrong");
  AST_SR_BUF: assert property (pwr_state == DDR4CI_PS_SREF |->
    !ibuf_ca_en && !ibuf_ck_odt_en)
    else $error("buffers on in self refresh");
  AST_SR_EXIT: assert property (clk_en && cke &&
    pwr_state == DDR4CI_PS_SREF |=> pwr_state == DDR4CI_PS_ACTIVE)
    else $error("self refresh exit missed");
endmodule

// ---- test/ddr4ci_host.sv ----
`timescale 1ns/100ps
module ddr4ci_host
  import ddr4ci_pkg::*;
(
  input wire logic sys_clk,
  output ddr4ci_ca_t ca,
  output logic cke
);
  initial begin
    ca = '1;
    cke = 1'b1;
  end
  // Falling-edge launch keeps pins stable at the rising sample
  task issue(input ddr4ci_ca_t v, input logic k);
    @(negedge sys_clk);
    ca <= v;
    cke <= k;
    @(negedge sys_clk);
    ca <= {1'b1, ~v[$bits(v)-2:0]};
  endtask
endmodule

// ---- test/ddr4ci_ca_decode_tb.sv ----
`timescale 1ns/100ps
`include "ddr4ci_defs.svh"
module ddr4ci_ca_decode_tb
  import ddr4ci_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] org = `DDR4CI_ORG_X8;
  logic [1:0] stack = `DDR4CI_STACK_1H;
  logic [2:0] die_id = 3'h0;
  ddr4ci_ca_t ca;
  logic cke;
  ddr4ci_cmd_t cmd;
  ddr4ci_pwr_t pwr_state;
  logic [15:0] bank_open;
  logic ibuf_ca_en, ibuf_ck_odt_en, dev_ready;
  int failures = 0;
  int checked = 0;
  ddr4ci_ca_t v;
  ddr4ci_ca_t n = '1;
  ddr4ci_op_t ops [7] = '{DDR4CI_OP_MRS, DDR4CI_OP_REF, DDR4CI_OP_PRE,
    DDR4CI_OP_RFU, DDR4CI_OP_WR, DDR4CI_OP_RD, DDR4CI_OP_ZQC};
  always #10 sys_clk = ~sys_clk;
  ddr4ci_host u_ddr4ci_host (.sys_clk, .ca, .cke);
  ddr4ci_ca_decode u_ddr4ci_ca_decode (.sys_clk, .rst_n, .clk_en(1'b1),
    .ca, .cke, .org, .stack, .die_id, .cmd, .pwr_state, .bank_open,
    .ibuf_ca_en, .ibuf_ck_odt_en, .dev_ready);
  function automatic ddr4ci_ca_t mk(logic act, logic [2:0] rcw,
    logic [13:0] a, logic [3:0] b);
    mk = {1'b0, act, rcw, 1'b0, a, b, die_id};
  endfunction
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  task go(input ddr4ci_ca_t c, input logic k);
    u_ddr4ci_host.issue(c, k);
  endtask
  task t_act;
    org = `DDR4CI_ORG_X4;
    v = mk(1'b0, 3'h5, 14'h2A5C, 4'h6);
    v.a17 = 1'b1;
    go(v, 1'b1);
    chk("valid", 1'b1, cmd.valid);
    chk("op", DDR4CI_OP_ACT, cmd.op);
    chk("row", 18'h36A5C, cmd.row);
    chk("open", 16'h0040, bank_open);
    chk("bank", 4'h6, {cmd.bg, cmd.ba});
    org = `DDR4CI_ORG_X8;
    go(v, 1'b1);
    chk("row", 18'h16A5C, cmd.row);
    $display("act done");
  endtask
  task t_rdwr;
    go(mk(1'b1, 3'h5, 14'h0533, 4'h6), 1'b1);
    chk("op", DDR4CI_OP_RD, cmd.op);
    chk("col", 10'h133, cmd.col);
    chk("ap", 1'b1, cmd.auto_pre);
    chk("bc", 1'b1, cmd.burst_chop);
    chk("open", 16'h0000, bank_open);
    go(mk(1'b1, 3'h4, 14'h1255, 4'h6), 1'b1);
    chk("op", DDR4CI_OP_WR, cmd.op);
    chk("col", 10'h255, cmd.col);
    chk("ap", 1'b0, cmd.auto_pre);
    chk("bc", 1'b0, cmd.burst_chop);
    $display("rdwr done");
  endtask
  task t_pre;
    go(mk(1'b0, 3'h0, 14'h0001, 4'h3), 1'b1);
    go(mk(1'b0, 3'h0, 14'h0002, 4'hC), 1'b1);
    chk("open", 16'h1008, bank_open);
    go(mk(1'b1, 3'h2, 14'h0000, 4'h3), 1'b1);
    chk("open", 16'h1000, bank_open);
    go(mk(1'b1, 3'h2, 14'h0400, 4'h0), 1'b1);
    chk("pre_all", 1'b1, cmd.pre_all);
    chk("open", 16'h0000, bank_open);
    $display("pre done");
  endtask
  task t_codes;
    go(mk(1'b1, 3'h0, 14'h1ABC, 4'h9), 1'b1);
    chk("opcode", 14'h1ABC, cmd.opcode);
    chk("mr_sel", 3'h1, cmd.mr_sel);
    for (int i = 0; i < 7; i++) begin
      go(mk(1'b1, i[2:0], 14'h1ABC, 4'h9), 1'b1);
      chk("op", ops[i], cmd.op);
    end
    $display("codes done");
  endtask
  task t_sel;
    v = mk(1'b0, 3'h0, 14'h0000, 4'h1);
    v.cs_n = 1'b1;
    go(v, 1'b1);
    chk("valid", 1'b0, cmd.valid);
    stack = `DDR4CI_STACK_2H;
    die_id = 3'h1;
    v.cs_n = 1'b0;
    v.cid = 3'h2;
    go(v, 1'b1);
    chk("valid", 1'b0, cmd.valid);
    v.cid = 3'h3;
    go(v, 1'b1);
    chk("valid", 1'b1, cmd.valid);
    chk("die", 3'h1, cmd.die);
    stack = `DDR4CI_STACK_8H;
    die_id = 3'h5;
    v.cid = 3'h1;
    go(v, 1'b1);
    chk("valid", 1'b0, cmd.valid);
    v.cid = 3'h5;
    go(v, 1'b1);
    chk("valid", 1'b1, cmd.valid);
    chk("die", 3'h5, cmd.die);
    // x16 ignores chip ID and the upper group bit
    org = `DDR4CI_ORG_X16;
    v.cid = 3'h2;
    v.bg = 2'h3;
    go(v, 1'b1);
    chk("valid", 1'b1, cmd.valid);
    chk("die", 3'h0, cmd.die);
    chk("bank", 4'h5, {cmd.bg, cmd.ba});
    chk("open", 16'h0022, bank_open);
    org = `DDR4CI_ORG_X8;
    stack = `DDR4CI_STACK_1H;
    die_id = 3'h0;
    $display("select done");
  endtask
  task t_pd;
    go(n, 1'b0);
    chk("pwr", DDR4CI_PS_APD, pwr_state);
    chk("ca_buf", 1'b0, ibuf_ca_en);
    chk("ck_buf", 1'b1, ibuf_ck_odt_en);
    go(mk(1'b0, 3'h0, 14'h0000, 4'h2), 1'b0);
    chk("valid", 1'b0, cmd.valid);
    chk("open", 16'h0022, bank_open);
    go(n, 1'b1);
    chk("pwr", DDR4CI_PS_ACTIVE, pwr_state);
    go(mk(1'b1, 3'h2, 14'h0400, 4'h0), 1'b1);
    go(n, 1'b0);
    chk("pwr", DDR4CI_PS_PPD, pwr_state);
    go(n, 1'b1);
    $display("powerdown done");
  endtask
  task t_sref;
    go(mk(1'b1, 3'h1, 14'h0000, 4'h0), 1'b0);
    chk("op", DDR4CI_OP_SRE, cmd.op);
    chk("pwr", DDR4CI_PS_SREF, pwr_state);
    chk("ck_buf", 1'b0, ibuf_ck_odt_en);
    chk("ca_buf", 1'b0, ibuf_ca_en);
    go(n, 1'b1);
    chk("pwr", DDR4CI_PS_ACTIVE, pwr_state);
    chk("ck_buf", 1'b1, ibuf_ck_odt_en);
    $display("selfrefresh done");
  endtask
  task end_of_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge sys_clk);
    chk("pwr", DDR4CI_PS_ACTIVE, pwr_state);
    chk("ready", 1'b0, dev_ready);
    chk("ca_buf", 1'b0, ibuf_ca_en);
    rst_n = 1'b1;
    @(negedge sys_clk);
    chk("ready", 1'b1, dev_ready);
    chk("ca_buf", 1'b1, ibuf_ca_en);
    t_act;
    t_rdwr;
    t_pre;
    t_codes;
    t_sel;
    t_pd;
    t_sref;
    end_of_test;
  end
  // Whole run is near 80 cycles
  initial begin
    repeat (2000) @(posedge sys_clk);
    failures++;
    end_of_test;
  end
endmodule
bind ddr4ci_ca_decode ddr4ci_ca_decode_chk u_ddr4ci_ca_decode_chk (
  .sys_clk, .rst_n, .clk_en, .ca, .cke, .die_id, .cmd, .pwr_state,
  .bank_open, .ibuf_ca_en, .ibuf_ck_odt_en, .dev_ready);
